// ===== rtl/adc_port_pkg.sv
// Purpose: Types shared by the converter serial port design.
// Assumes: Constants live in adc_port_regs.svh.
// Notes:   Types only.
package adc_port_pkg;

  typedef enum logic [1:0] {
    rate_64,
    rate_128,
    rate_256
  } rate_sel_t;

  typedef enum logic {
    wr_idle,
    wr_shift
  } wr_state_t;

endpackage : adc_port_pkg

// ===== rtl/adc_port_regs.svh
// Purpose: Constants for the converter serial port and control pins.
// Assumes: Master clock of 20 MHz, one clock domain.
// Notes:   Definitions only; included by bare name.
`ifndef ADC_PORT_REGS_SVH
`define ADC_PORT_REGS_SVH

// ---------------------------------------------------------------------
// Clock and framing
// ---------------------------------------------------------------------
`define MCLK_PERIOD_NS 50
`define OUT_FRAME_BITS 6'd32
`define WRITE_BITS 6'd32
`define WORD_HALF 16
`define DATA_BITS 24
`define STATUS_BITS 8

// Half periods of the modulator clock, in master clocks, less one.
`define HALF_DIV_NORMAL 1'b0
`define HALF_DIV_LOW 1'b1

// ---------------------------------------------------------------------
// Decimation ratios, counted in modulator clocks
// ---------------------------------------------------------------------
`define DEC_64 9'd64
`define DEC_128 9'd128
`define DEC_256 9'd256

// ---------------------------------------------------------------------
// Three-level rate pin: bit 1 is pin driven, bit 0 is its level
// ---------------------------------------------------------------------
`define RATE_PIN_DRIVEN 1
`define RATE_PIN_LEVEL 0

`endif

// ===== rtl/adc_serial_port.sv
// Purpose: Serial port, restart, power-down, rate select and overrange
//          logic of a sigma-delta converter.
// Assumes: All inputs synchronous to mclk_i; conversion data comes from a
//          filter outside this block.
// Notes:   The bit clock is a divided master clock, not a second domain.
//
// Notes on behaviour
// - Bit clock equals the modulator clock.
// - Output strobe low exactly 32 bit clocks.
// - Output bits change on bit clock rise.
// - Each frame carries data plus status.
// - Strobe low at fall: next fall takes bit.
// - Write is address word then data word.
// - Restart falling edge resets decimation filter.
// - Power-down low holds everything in reset.
// - Supply 64x, floating 128x, ground 256x.
// - Overrange output high near input limit.
// - Word rate follows master clock.
// - Modulator clock is master over two/four.
`timescale 1ns/1ps
`include "adc_port_regs.svh"

module adc_serial_port (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Control pins
  input wire logic reset_powerdown_n_i,
  input wire logic low_power_i,
  input wire logic [1:0] oversample_select_i,
  input wire logic filter_restart_i,
  input wire logic near_limit_i,
  // Conversion result from the filter
  input wire logic [`DATA_BITS-1:0] conversion_data_i,
  // Serial output
  output logic serial_clock_o,
  output logic output_frame_strobe_n_o,
  output logic serial_out_line_o,
  // Serial input
  input wire logic input_frame_strobe_n_i,
  input wire logic serial_in_line_i,
  // Decoded write
  output logic [`WORD_HALF-1:0] write_addr_o,
  output logic [`WORD_HALF-1:0] write_data_o,
  output logic write_valid_o,
  // Status
  output logic overrange_o,
  output logic filter_reset_o,
  output logic powered_down_o,
  output adc_port_pkg::rate_sel_t rate_select_o
);
  import adc_port_pkg::*;

  logic core_rst;
  logic bclk_rise;
  logic bclk_fall;

  assign core_rst = ~rst_n_i | ~reset_powerdown_n_i;

  // ---------------------------------------------------------------------
  // Modulator and bit clock
  // ---------------------------------------------------------------------
  // Output is the divider flop itself, so the pin stays glitch free.
  modulator_clock_gen u_clk_gen (
    .mclk_i(mclk_i),
    .core_rst_i(core_rst),
    .low_power_i(low_power_i),
    .modulator_clock_o(serial_clock_o),
    .rise_o(bclk_rise),
    .fall_o(bclk_fall)
  );

  // ---------------------------------------------------------------------
  // Control pins: rate, overrange, restart, power-down
  // ---------------------------------------------------------------------
  rate_sel_t rate_ff;
  rate_sel_t nxt_rate;
  logic restart_d_ff;
  logic nxt_restart_d;
  logic filt_rst_ff;
  logic nxt_filt_rst;
  logic ovr_ff;
  logic nxt_ovr;
  logic pd_ff;
  logic nxt_pd;
  logic restart_fall;

  always_comb begin
    nxt_rate = rate_ff;
    // The setting is only taken while held in reset, so a running word
    // clock never sees its ratio change mid-frame.
    if (core_rst) begin
      if (!oversample_select_i[`RATE_PIN_DRIVEN]) begin
        nxt_rate = rate_128;
      end else if (oversample_select_i[`RATE_PIN_LEVEL]) begin
        nxt_rate = rate_64;
      end else begin
        nxt_rate = rate_256;
      end
    end
    restart_fall = restart_d_ff & ~filter_restart_i;
    nxt_restart_d = filter_restart_i;
    nxt_filt_rst = restart_fall;
    nxt_ovr = near_limit_i;
    nxt_pd = ~reset_powerdown_n_i;
  end

  always_ff @(posedge mclk_i) begin
    rate_ff <= nxt_rate;
    pd_ff <= nxt_pd;
    if (core_rst) begin
      restart_d_ff <= 1'b1;
      filt_rst_ff <= 1'b0;
      ovr_ff <= 1'b0;
    end else begin
      restart_d_ff <= nxt_restart_d;
      filt_rst_ff <= nxt_filt_rst;
      ovr_ff <= nxt_ovr;
    end
  end

  assign rate_select_o = rate_ff;
  assign overrange_o = ovr_ff;
  assign filter_reset_o = filt_rst_ff;
  assign powered_down_o = pd_ff;

  // ---------------------------------------------------------------------
  // Output word timing and shift register
  // ---------------------------------------------------------------------
  logic [8:0] word_cnt_ff;
  logic [8:0] nxt_word_cnt;
  logic [8:0] dec_lim;
  logic [5:0] out_cnt_ff;
  logic [5:0] nxt_out_cnt;
  logic [31:0] out_sh_ff;
  logic [31:0] nxt_out_sh;
  logic fso_n_ff;
  logic nxt_fso_n;
  logic sdo_ff;
  logic nxt_sdo;
  logic word_due;
  logic [31:0] frame_word;

  always_comb begin
    unique case (rate_ff)
      rate_64: dec_lim = `DEC_64;
      rate_128: dec_lim = `DEC_128;
      rate_256: dec_lim = `DEC_256;
      default: dec_lim = `DEC_128;
    endcase
    // Words come every dec_lim modulator clocks, so the rate tracks mclk.
    word_due = bclk_rise && (word_cnt_ff == dec_lim - 9'd1);
    nxt_word_cnt = word_cnt_ff;
    if (restart_fall) begin
      nxt_word_cnt = 9'd0;
    end else if (bclk_rise) begin
      nxt_word_cnt = word_due ? 9'd0 : word_cnt_ff + 9'd1;
    end
    frame_word = {conversion_data_i, ovr_ff, pd_ff, rate_ff,
                  low_power_i, 3'h0};
    nxt_out_cnt = out_cnt_ff;
    nxt_out_sh = out_sh_ff;
    nxt_fso_n = fso_n_ff;
    nxt_sdo = sdo_ff;
    if (bclk_rise) begin
      if (word_due && out_cnt_ff == 6'd0) begin
        nxt_out_cnt = `OUT_FRAME_BITS;
        nxt_fso_n = 1'b0;
        nxt_sdo = frame_word[31];
        nxt_out_sh = {frame_word[30:0], 1'b0};
      end else if (out_cnt_ff == 6'd1) begin
        nxt_out_cnt = 6'd0;
        nxt_fso_n = 1'b1;
        nxt_sdo = 1'b0;
      end else if (out_cnt_ff != 6'd0) begin
        nxt_out_cnt = out_cnt_ff - 6'd1;
        nxt_sdo = out_sh_ff[31];
        nxt_out_sh = {out_sh_ff[30:0], 1'b0};
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (core_rst) begin
      word_cnt_ff <= 9'd0;
      out_cnt_ff <= 6'd0;
      out_sh_ff <= 32'h0;
      fso_n_ff <= 1'b1;
      sdo_ff <= 1'b0;
    end else begin
      word_cnt_ff <= nxt_word_cnt;
      out_cnt_ff <= nxt_out_cnt;
      out_sh_ff <= nxt_out_sh;
      fso_n_ff <= nxt_fso_n;
      sdo_ff <= nxt_sdo;
    end
  end

  assign output_frame_strobe_n_o = fso_n_ff;
  assign serial_out_line_o = sdo_ff;

  // ---------------------------------------------------------------------
  // Write receiver
  // ---------------------------------------------------------------------
  wr_state_t wr_state_ff;
  wr_state_t nxt_wr_state;
  logic [5:0] in_cnt_ff;
  logic [5:0] nxt_in_cnt;
  logic [31:0] in_sh_ff;
  logic [31:0] nxt_in_sh;
  logic [`WORD_HALF-1:0] wr_addr_ff;
  logic [`WORD_HALF-1:0] nxt_wr_addr;
  logic [`WORD_HALF-1:0] wr_data_ff;
  logic [`WORD_HALF-1:0] nxt_wr_data;
  logic wr_valid_ff;
  logic nxt_wr_valid;

  always_comb begin
    nxt_wr_state = wr_state_ff;
    nxt_in_cnt = in_cnt_ff;
    nxt_in_sh = in_sh_ff;
    nxt_wr_addr = wr_addr_ff;
    nxt_wr_data = wr_data_ff;
    nxt_wr_valid = 1'b0;
    if (bclk_fall) begin
      unique case (wr_state_ff)
        wr_idle: begin
          if (!input_frame_strobe_n_i) begin
            nxt_wr_state = wr_shift;
            nxt_in_cnt = 6'd0;
          end
        end
        wr_shift: begin
          // The host has the MSB valid on this first fall.
          nxt_in_sh = {in_sh_ff[30:0], serial_in_line_i};
          nxt_in_cnt = in_cnt_ff + 6'd1;
          if (in_cnt_ff == `WRITE_BITS - 6'd1) begin
            // Strobe still low here is not a new write: a single device
            // relies on the host releasing it within 32 periods.
            nxt_wr_state = wr_idle;
            nxt_wr_addr = in_sh_ff[30:15];
            nxt_wr_data = {in_sh_ff[14:0], serial_in_line_i};
            nxt_wr_valid = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (core_rst) begin
      wr_state_ff <= wr_idle;
      in_cnt_ff <= 6'd0;
      in_sh_ff <= 32'h0;
      wr_addr_ff <= 16'h0;
      wr_data_ff <= 16'h0;
      wr_valid_ff <= 1'b0;
    end else begin
      wr_state_ff <= nxt_wr_state;
      in_cnt_ff <= nxt_in_cnt;
      in_sh_ff <= nxt_in_sh;
      wr_addr_ff <= nxt_wr_addr;
      wr_data_ff <= nxt_wr_data;
      wr_valid_ff <= nxt_wr_valid;
    end
  end

  assign write_addr_o = wr_addr_ff;
  assign write_data_o = wr_data_ff;
  assign write_valid_o = wr_valid_ff;

endmodule : adc_serial_port

// ===== rtl/modulator_clock_gen.sv
// Purpose: Divides the master clock into the modulator clock.
// Assumes: Synchronous active-high reset from the parent.
// Notes:   Rise and fall pulses mark the master edge that moves the clock.
`timescale 1ns/1ps
`include "adc_port_regs.svh"

module modulator_clock_gen (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic core_rst_i,
  // Mode
  input wire logic low_power_i,
  // Modulator clock and its edge markers
  output logic modulator_clock_o,
  output logic rise_o,
  output logic fall_o
);

  logic div_cnt_ff;
  logic nxt_div_cnt;
  logic clk_ff;
  logic nxt_clk;
  logic half_lim;
  logic at_lim;

  // ---------------------------------------------------------------------
  // Divider
  // ---------------------------------------------------------------------
  always_comb begin
    half_lim = low_power_i ? `HALF_DIV_LOW : `HALF_DIV_NORMAL;
    at_lim = (div_cnt_ff == half_lim);
    nxt_div_cnt = at_lim ? 1'b0 : div_cnt_ff + 1'b1;
    nxt_clk = at_lim ? ~clk_ff : clk_ff;
  end

  always_ff @(posedge mclk_i) begin
    if (core_rst_i) begin
      div_cnt_ff <= 1'b0;
      clk_ff <= 1'b0;
    end else begin
      div_cnt_ff <= nxt_div_cnt;
      clk_ff <= nxt_clk;
    end
  end

  assign modulator_clock_o = clk_ff;
  assign rise_o = ~core_rst_i & at_lim & ~clk_ff;
  assign fall_o = ~core_rst_i & at_lim & clk_ff;

endmodule : modulator_clock_gen

// ===== sim/adc_port_sva.sv
// Purpose: Assertions on the converter serial port pins.
// Assumes: Both resets are synchronous and active low.
// Notes: Sees only the ports of adc_serial_port.
`timescale 1ns/1ps
module adc_port_sva (
  // Clock, resets and pins
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic reset_powerdown_n_i,
  input wire logic low_power_i,
  input wire logic [1:0] oversample_select_i,
  input wire logic filter_restart_i,
  input wire logic near_limit_i,
  // Outputs
  input wire logic serial_clock_o,
  input wire logic output_frame_strobe_n_o,
  input wire logic serial_out_line_o,
  input wire logic write_valid_o,
  input wire logic overrange_o,
  input wire logic filter_reset_o,
  input wire logic powered_down_o,
  input wire adc_port_pkg::rate_sel_t rate_select_o
);
  import adc_port_pkg::*;
  logic [5:0] rise_cnt_ff;
  logic [5:0] nxt_rise_cnt;
  logic fs_q_ff;
  logic sc_q_ff;

  function automatic rate_sel_t pin_rate(logic [1:0] p);
    return (p == 2'h3) ? rate_64 : (p == 2'h2) ? rate_256 : rate_128;
  endfunction : pin_rate

  // ----
  // Bit clock rises inside an output frame
  // ----
  always_comb begin
    nxt_rise_cnt = rise_cnt_ff;
    if (!output_frame_strobe_n_o && fs_q_ff) nxt_rise_cnt = 6'h1;
    else if (!output_frame_strobe_n_o && serial_clock_o && !sc_q_ff)
      nxt_rise_cnt = rise_cnt_ff + 6'h1;
  end

  always_ff @(posedge mclk_i) begin
    rise_cnt_ff <= nxt_rise_cnt;
    fs_q_ff <= output_frame_strobe_n_o;
    sc_q_ff <= serial_clock_o;
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i || !reset_powerdown_n_i);

  property p_frame_len;
    $rose(output_frame_strobe_n_o) |-> rise_cnt_ff == 6'h20;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("output frame length wrong");
  property p_sdo_launch;
    !$stable(serial_out_line_o) |-> $rose(serial_clock_o);
  endproperty
  a_sdo_launch: assert property (p_sdo_launch)
    else $error("serial bit changed off a rise");
  property p_sclk_norm;
    $rose(serial_clock_o) && !low_power_i |=> $fell(serial_clock_o);
  endproperty
  a_sclk_norm: assert property (p_sclk_norm)
    else $error("bit clock not master over two");
  property p_sclk_low;
    $rose(serial_clock_o) && low_power_i |=>
      serial_clock_o ##1 $fell(serial_clock_o);
  endproperty
  a_sclk_low: assert property (p_sclk_low)
    else $error("bit clock not master over four");
  property p_restart;
    $fell(filter_restart_i) |-> ##[1:2] filter_reset_o ##1 !filter_reset_o;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart gave no single pulse");
  property p_overrange;
    $past(rst_n_i) && $past(reset_powerdown_n_i) |->
      overrange_o == $past(near_limit_i);
  endproperty
  a_overrange: assert property (p_overrange)
    else $error("overrange does not follow input");
  property p_powerdown;
    disable iff (!rst_n_i) !reset_powerdown_n_i |=> powered_down_o &&
      output_frame_strobe_n_o && !serial_clock_o && !write_valid_o;
  endproperty
  a_powerdown: assert property (p_powerdown)
    else $error("power-down did not hold reset");
  property p_rate_capture;
    $rose(rst_n_i) |-> rate_select_o == pin_rate($past(oversample_select_i));
  endproperty
  a_rate_capture: assert property (p_rate_capture)
    else $error("rate pin decoded wrong");
  property p_rate_hold;
    $past(rst_n_i) && $past(reset_powerdown_n_i) |-> $stable(rate_select_o);
  endproperty
  a_rate_hold: assert property (p_rate_hold)
    else $error("rate changed outside reset");

  c_frame: cover property ($fell(output_frame_strobe_n_o));
  c_write: cover property (write_valid_o);
  c_restart: cover property (filter_reset_o);
endmodule : adc_port_sva

bind adc_serial_port adc_port_sva i_sva (
  .mclk_i(mclk_i),
  .rst_n_i(rst_n_i),
  .reset_powerdown_n_i(reset_powerdown_n_i),
  .low_power_i(low_power_i),
  .oversample_select_i(oversample_select_i),
  .filter_restart_i(filter_restart_i),
  .near_limit_i(near_limit_i),
  .serial_clock_o(serial_clock_o),
  .output_frame_strobe_n_o(output_frame_strobe_n_o),
  .serial_out_line_o(serial_out_line_o),
  .write_valid_o(write_valid_o),
  .overrange_o(overrange_o),
  .filter_reset_o(filter_reset_o),
  .powered_down_o(powered_down_o),
  .rate_select_o(rate_select_o)
);

// ===== sim/host_port_model.sv
// Purpose: Host that writes 32-bit words into the serial input.
// Assumes: Changes its lines at master clock falls only.
// Notes: The data line flips after release so stale bits never match.
`timescale 1ns/1ps
module host_port_model (
  // Clocks
  input wire logic mclk_i,
  input wire logic serial_clock_i,
  // Serial input of the device
  output logic strobe_n_o,
  output logic data_o
);
  initial begin
    strobe_n_o = 1'b1;
    data_o = 1'b0;
  end

  task automatic send(input logic [15:0] addr, input logic [15:0] data);
    logic [31:0] word;
    word = {addr, data};
    @(posedge serial_clock_i);
    @(negedge mclk_i);
    strobe_n_o = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      @(posedge serial_clock_i);
      @(negedge mclk_i);
      strobe_n_o = 1'b1;
      data_o = word[i];
    end
    @(negedge serial_clock_i);
    @(negedge mclk_i);
    data_o = ~data_o;
  endtask : send
endmodule : host_port_model

// ===== sim/testbench.sv
// Purpose: Self-checking bench for adc_serial_port.
// Assumes: Host writes come from host_port_model.
// Notes: Each round resets with one rate pin code and power mode.
`timescale 1ns/1ps
module testbench;
  import adc_port_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic reset_powerdown_n_i = 1'b1;
  logic low_power_i = 1'b0;
  logic [1:0] oversample_select_i = 2'h3;
  logic filter_restart_i = 1'b1;
  logic near_limit_i = 1'b0;
  logic [23:0] conversion_data_i = 24'h0;
  logic input_frame_strobe_n_i;
  logic serial_in_line_i;
  logic serial_clock_o;
  logic output_frame_strobe_n_o;
  logic serial_out_line_o;
  logic [15:0] write_addr_o;
  logic [15:0] write_data_o;
  logic write_valid_o;
  logic overrange_o;
  logic filter_reset_o;
  logic powered_down_o;
  rate_sel_t rate_select_o;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] word;
  logic [15:0] addr;
  logic [15:0] data;
  logic [1:0] code;
  logic seen;
  time t0;
  time t1;

  adc_serial_port i_dut (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .reset_powerdown_n_i(reset_powerdown_n_i),
    .low_power_i(low_power_i),
    .oversample_select_i(oversample_select_i),
    .filter_restart_i(filter_restart_i),
    .near_limit_i(near_limit_i),
    .conversion_data_i(conversion_data_i),
    .serial_clock_o(serial_clock_o),
    .output_frame_strobe_n_o(output_frame_strobe_n_o),
    .serial_out_line_o(serial_out_line_o),
    .input_frame_strobe_n_i(input_frame_strobe_n_i),
    .serial_in_line_i(serial_in_line_i),
    .write_addr_o(write_addr_o),
    .write_data_o(write_data_o),
    .write_valid_o(write_valid_o),
    .overrange_o(overrange_o),
    .filter_reset_o(filter_reset_o),
    .powered_down_o(powered_down_o),
    .rate_select_o(rate_select_o)
  );
  host_port_model i_host (
    .mclk_i(mclk_i),
    .serial_clock_i(serial_clock_o),
    .strobe_n_o(input_frame_strobe_n_i),
    .data_o(serial_in_line_i)
  );

  initial begin
    forever #25 mclk_i = ~mclk_i;
  end

  // A run well past all eight rounds together means a hang.
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      final_report();
    end
  end

  function automatic rate_sel_t exp_rate(logic [1:0] p);
    return (p == 2'h3) ? rate_64 : (p == 2'h2) ? rate_256 : rate_128;
  endfunction : exp_rate

  function automatic int exp_gap(logic [1:0] p, logic lp);
    return (p == 2'h3 ? 64 : p == 2'h2 ? 256 : 128) * (lp ? 4 : 2);
  endfunction : exp_gap

  task automatic check(input logic [39:0] got, input logic [39:0] want);
    num_checks++;
    if (got !== want) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, got, want);
    end
  endtask : check

  task automatic final_report();
    if (error_cnt == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  task automatic get_frame();
    @(negedge output_frame_strobe_n_o);
    t0 = $time;
    for (int i = 0; i < 32; i++) begin
      @(negedge serial_clock_o);
      word = {word[30:0], serial_out_line_o};
    end
  endtask : get_frame

  // ----
  // Rounds over every pin code in both power modes
  // ----
  initial begin
    void'($urandom(74545));
    repeat (12) @(negedge mclk_i);
    rst_n_i = 1'b1;
    for (int r = 0; r < 8; r++) begin
      @(negedge mclk_i);
      rst_n_i = 1'b0;
      oversample_select_i = 2'(r);
      code = 2'(r);
      low_power_i = r[2];
      near_limit_i = 1'($urandom);
      conversion_data_i = (r == 0) ? 24'hffffff : 24'($urandom);
      repeat (2) @(negedge mclk_i);
      rst_n_i = 1'b1;
      check(rate_select_o, exp_rate(oversample_select_i));
      // A pin change while running must not reach the rate in use.
      oversample_select_i = ~code;
      get_frame();
      t1 = t0;
      get_frame();
      check(40'((t0 - t1) / 50),
            exp_gap(code, low_power_i));
      check(word, {conversion_data_i, near_limit_i, 1'b0,
            2'(exp_rate(code)), low_power_i, 3'h0});
      check(overrange_o, near_limit_i);
      check(rate_select_o, exp_rate(code));
      addr = (r == 0) ? 16'hffff : 16'($urandom);
      data = (r == 1) ? 16'h0 : 16'($urandom);
      seen = 1'b0;
      // Valid stands for one clock only, so it is watched during the send.
      fork
        i_host.send(addr, data);
        for (int i = 0; i < 200 && !seen; i++) begin
          @(negedge mclk_i);
          seen = (write_valid_o === 1'b1);
        end
      join
      check({seen, write_addr_o, write_data_o}, {1'b1, addr, data});
      filter_restart_i = 1'b0;
      seen = 1'b0;
      repeat (3) begin
        @(negedge mclk_i);
        seen = seen | (filter_reset_o === 1'b1);
      end
      check(seen, 1'b1);
      filter_restart_i = 1'b1;
      reset_powerdown_n_i = 1'b0;
      repeat (2) @(negedge mclk_i);
      check({powered_down_o, output_frame_strobe_n_o, serial_clock_o},
            3'h6);
      reset_powerdown_n_i = 1'b1;
      repeat (2) @(negedge mclk_i);
      check(powered_down_o, 1'b0);
    end
    final_report();
  end
endmodule : testbench
